//--- rtl/dual_clock_fifo_flag_modes.sv
/*
 * Mode-selectable first-in first-out buffer, 1024 words of 36 bits, with
 * standard (empty/full) or fall-through (output ready/input ready) timing,
 * plus almost-empty, half-full and almost-full flags and offset registers.
 * Assumes writer, reader and register master all run on ref_clk.
 */
// Operation
// - Mode pin sampled during reset, held until the next reset.
// - Pin low at reset selects standard mode with empty and full flags.
// - Pin high at reset selects fall-through mode with ready flags.
// - Fall-through: first word reaches output after three edges, no read enable.
// - Write enable low captures the input word on the clock edge.
// - First write clears empty, or asserts output ready in fall-through.
// - Standard: almost-empty goes high once n+1 words are stored.
// - Standard: half-full goes low at word 513.
// - Standard: almost-full goes low after 1024-m writes.
// - Standard: full goes low after 1024 writes; further writes blocked.
// - Standard: first read from full releases full; other flags follow.
// - Standard: almost-empty goes low when n words remain.
// - Standard: empty goes low after last word; reads then blocked.
// - Output ready released after last word; read enable ignored when empty.
// - Empty, full, input ready have two stages; output ready has three.
// - Fall-through: almost-empty goes high once n+2 words are written.
// - Fall-through: half-full goes low at word 514.
// - Fall-through: almost-full goes low after 1025-m writes.
// - Fall-through: input ready high after 1025 writes; output register holds one.
// - Fall-through: first read from full drops input ready; other flags follow.
// - Fall-through: almost-empty goes low when n+1 words remain.
// - Offsets n and m range from 0 to depth minus one.
`timescale 1ns/100ps
`default_nettype none

module dual_clock_fifo_flag_modes
    import fifo_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      mode_select_serial_in,
    input  wire logic                      write_enable_n,
    input  wire logic [DATA_WIDTH-1:0]     data_in,
    input  wire logic                      read_enable_n,
    input  wire logic [REG_ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [REG_DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output var  logic [REG_DATA_WIDTH-1:0] reg_rdata,
    output var  logic [DATA_WIDTH-1:0]     data_out,
    output var  logic                      fall_through_mode,
    output var  logic                      empty_flag_n,
    output var  logic                      full_flag_n,
    output var  logic                      input_space_n,
    output var  logic                      output_ready_n,
    output var  logic                      almost_empty_flag_n,
    output var  logic                      almost_full_flag_n,
    output var  logic                      half_full_flag_n
);

    logic                      mode_sync;
    logic                      mode_reg;
    offsets_type               offsets_reg;
    flags_type                 flags_reg;
    flags_type                 flags_next;
    logic [DATA_WIDTH-1:0]     mem [DEPTH];
    logic [DATA_WIDTH-1:0]     data_out_reg;
    logic [REG_DATA_WIDTH-1:0] reg_rdata_reg;
    logic [ADDR_WIDTH-1:0]     wr_ptr_reg;
    logic [ADDR_WIDTH-1:0]     rd_ptr_reg;
    logic [COUNT_WIDTH-1:0]    mem_count_reg;
    logic [COUNT_WIDTH-1:0]    mem_count_next;
    logic                      out_valid_reg;
    logic                      out_valid_next;
    logic [1:0]                nonempty_pipe_reg;
    logic                      empty_stage_reg;
    logic                      full_stage_reg;
    logic [COUNT_WIDTH-1:0]    total;
    logic [COUNT_WIDTH-1:0]    total_next;
    logic [COUNT_WIDTH-1:0]    capacity;
    logic                      write_go;
    logic                      std_read_go;
    logic                      pop_go;
    logic                      load_go;
    logic                      mem_read;
    logic [THR_WIDTH-1:0]      total_wide;
    logic [THR_WIDTH-1:0]      ae_threshold;
    logic [THR_WIDTH-1:0]      hf_threshold;
    logic [THR_WIDTH-1:0]      af_threshold;
    logic [THR_WIDTH-1:0]      mode_wide;

    // Mode pin passes the three-stage synchroniser
    pin_sync u_mode_sync (
        .clk  (ref_clk),
        .din  (mode_select_serial_in),
        .dout (mode_sync)
    );

    // Mode follows the pin only while reset is held, then stays fixed
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mode_reg <= mode_sync;
        end
    end

    // Words held: memory plus the fall-through output register
    assign total    = mem_count_reg + COUNT_WIDTH'(mode_reg & out_valid_reg);
    assign capacity = DEPTH_COUNT + COUNT_WIDTH'(mode_reg);

    // Write accepted while space remains in both count and memory
    assign write_go = ~write_enable_n & (total != capacity)
                    & (mem_count_reg != DEPTH_COUNT);

    // Standard read: every word needs read enable, ignored when empty
    assign std_read_go = ~mode_reg & ~read_enable_n
                       & (mem_count_reg != ZERO_COUNT);

    // Fall-through: read enable consumes the word already on the outputs
    assign pop_go = mode_reg & ~read_enable_n & out_valid_reg;

    // Fall-through refill, gated by the two-edge visibility of stored data
    assign load_go = mode_reg & (mem_count_reg != ZERO_COUNT) & nonempty_pipe_reg[1]
                   & (pop_go | ~out_valid_reg);

    assign mem_read = std_read_go | load_go;

    // Next occupancy
    always_comb begin
        mem_count_next = mem_count_reg + COUNT_WIDTH'(write_go) - COUNT_WIDTH'(mem_read);
        if (load_go) begin
            out_valid_next = 1'b1;
        end else if (pop_go) begin
            out_valid_next = 1'b0;
        end else begin
            out_valid_next = out_valid_reg;
        end
        total_next = mem_count_next + COUNT_WIDTH'(mode_reg & out_valid_next);
    end

    // Storage array
    always_ff @(posedge ref_clk) begin
        if (write_go) begin
            mem[wr_ptr_reg] <= data_in;
        end
    end

    // Pointers and counts
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            mem_count_reg <= ZERO_COUNT;
            out_valid_reg <= 1'b0;
        end else begin
            if (write_go) begin
                wr_ptr_reg <= wr_ptr_reg + ADDR_WIDTH'(1);
            end
            if (mem_read) begin
                rd_ptr_reg <= rd_ptr_reg + ADDR_WIDTH'(1);
            end
            mem_count_reg <= mem_count_next;
            out_valid_reg <= out_valid_next;
        end
    end

    // Two edges of delay before a fresh word may fall through
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            nonempty_pipe_reg <= 2'h0;
        end else begin
            nonempty_pipe_reg <= {nonempty_pipe_reg[0], mem_count_next != ZERO_COUNT};
        end
    end

    // Output data register, loaded by a read or a fall-through
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            data_out_reg <= '0;
        end else if (mem_read) begin
            data_out_reg <= mem[rd_ptr_reg];
        end
    end

    // Thresholds shift by one word in fall-through mode
    always_comb begin
        mode_wide    = THR_WIDTH'(mode_reg);
        total_wide   = THR_WIDTH'(total_next);
        ae_threshold = THR_WIDTH'(offsets_reg.empty_offset) + 12'h001 + mode_wide;
        hf_threshold = THR_WIDTH'(HALF_COUNT) + 12'h001 + mode_wide;
        af_threshold = THR_WIDTH'(DEPTH_COUNT) - THR_WIDTH'(offsets_reg.full_offset)
                     + mode_wide;
    end

    // First stage of the empty and full indications
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            empty_stage_reg <= 1'b1;
            full_stage_reg  <= 1'b0;
        end else begin
            empty_stage_reg <= (total_next == ZERO_COUNT);
            full_stage_reg  <= (total_next == capacity);
        end
    end

    // Pin flag values; other-mode flags idle high, except input_space_n, held low in standard mode
    always_comb begin
        flags_next.empty_n        = mode_reg | ~empty_stage_reg;
        flags_next.full_n         = mode_reg | ~full_stage_reg;
        flags_next.input_space_n  = mode_reg & full_stage_reg;
        flags_next.output_ready_n = ~(mode_reg & out_valid_next);
        flags_next.almost_empty_n = (total_wide >= ae_threshold);
        flags_next.half_full_n    = ~(total_wide >= hf_threshold);
        flags_next.almost_full_n  = ~(total_wide >= af_threshold);
    end

    // Flag register bank
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Offset registers; the field width keeps them within 0 to depth-1
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            offsets_reg.empty_offset <= EMPTY_OFFSET_RESET;
            offsets_reg.full_offset  <= FULL_OFFSET_RESET;
        end else if (reg_write) begin
            if (reg_addr == EMPTY_OFFSET_ADDR) begin
                offsets_reg.empty_offset <= reg_wdata[ADDR_WIDTH-1:0];
            end
            if (reg_addr == FULL_OFFSET_ADDR) begin
                offsets_reg.full_offset <= reg_wdata[ADDR_WIDTH-1:0];
            end
        end
    end

    // Read data stand for one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata_reg <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                EMPTY_OFFSET_ADDR: reg_rdata_reg <= REG_DATA_WIDTH'(offsets_reg.empty_offset);
                FULL_OFFSET_ADDR:  reg_rdata_reg <= REG_DATA_WIDTH'(offsets_reg.full_offset);
                STATUS_ADDR: begin
                    reg_rdata_reg <= '0;
                    reg_rdata_reg[STATUS_COUNT_LSB +: COUNT_WIDTH] <= total;
                    reg_rdata_reg[STATUS_MODE_BIT] <= mode_reg;
                    reg_rdata_reg[STATUS_FLAGS_LSB +: $bits(flags_type)] <= flags_reg;
                end
                default: reg_rdata_reg <= '0;
            endcase
        end else begin
            reg_rdata_reg <= '0;
        end
    end

    // Outputs straight from registers
    assign reg_rdata           = reg_rdata_reg;
    assign data_out            = data_out_reg;
    assign fall_through_mode   = mode_reg;
    assign empty_flag_n        = flags_reg.empty_n;
    assign full_flag_n         = flags_reg.full_n;
    assign input_space_n       = flags_reg.input_space_n;
    assign output_ready_n      = flags_reg.output_ready_n;
    assign almost_empty_flag_n = flags_reg.almost_empty_n;
    assign almost_full_flag_n  = flags_reg.almost_full_n;
    assign half_full_flag_n    = flags_reg.half_full_n;

    // Mode never moves outside reset
    a_mode_held: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        reset_n |=> $stable(mode_reg))
        else $error("mode changed outside reset");

    // First word falls through on the third edge after the write
    a_fall_through_time: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (mode_reg && mem_count_reg == ZERO_COUNT && !out_valid_reg && write_go)
        |=> !out_valid_reg ##1 !out_valid_reg ##1 (out_valid_reg && !output_ready_n))
        else $error("fall-through word not ready on third edge");

    // Empty flag shows low one edge after the buffer sits empty
    a_std_empty_flag: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (!mode_reg && total == ZERO_COUNT && $past(total) == ZERO_COUNT) |=> !empty_flag_n)
        else $error("empty flag not low on empty buffer");

    // Read pointer frozen while nothing is stored
    a_empty_read_ignored: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (mem_count_reg == ZERO_COUNT) |=> $stable(rd_ptr_reg))
        else $error("read taken from empty memory");

    // Write pointer frozen when full
    a_full_write_blocked: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (total == capacity) |=> $stable(wr_ptr_reg))
        else $error("write taken while full");

    // Full flag low at 1024 stored words in standard mode
    a_std_full_flag: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (!mode_reg && total == DEPTH_COUNT && $past(total) == DEPTH_COUNT) |=> !full_flag_n)
        else $error("full flag not low at 1024 words");

    // Input ready high at 1025 stored words in fall-through mode
    a_ft_input_space: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (mode_reg && total == 11'h401 && $past(total) == 11'h401) |=> input_space_n)
        else $error("input ready not high at 1025 words");

    // Half-full at 513 words standard, 514 fall-through
    a_half_full_level: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ((!mode_reg && total >= 11'h201) || (mode_reg && total >= 11'h202))
        |-> !half_full_flag_n)
        else $error("half-full flag wrong at threshold");

    // Almost-empty low at or below n words standard, n+1 fall-through
    a_almost_empty_level: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ($stable(offsets_reg) && (THR_WIDTH'(total) <= THR_WIDTH'(offsets_reg.empty_offset)
            + THR_WIDTH'(mode_reg))) |-> !almost_empty_flag_n)
        else $error("almost-empty flag high at or below offset");

    // Almost-full low from 1024-m words standard, 1025-m fall-through
    a_almost_full_level: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ($stable(offsets_reg) && (THR_WIDTH'(total) + THR_WIDTH'(offsets_reg.full_offset)
            >= 12'h400 + THR_WIDTH'(mode_reg))) |-> !almost_full_flag_n)
        else $error("almost-full flag high past threshold");

    // Empty flag released two edges after the first write in standard mode
    a_std_first_write: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (!mode_reg && total == ZERO_COUNT && write_go) |=> ##1 empty_flag_n)
        else $error("empty flag not released after first write");

    // Output ready released once the last word leaves in fall-through mode
    a_ft_ready_release: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (mode_reg && pop_go && mem_count_reg == ZERO_COUNT) |=> output_ready_n)
        else $error("output ready held after last word");

endmodule

`default_nettype wire

//--- rtl/fifo_pkg.sv
/*
 * Shared constants and types for the mode-selectable first-in first-out buffer:
 * geometry, register offsets and field positions, reset values and flag bundles.
 * Assumes a single 200 MHz clock domain for both the writer and the reader.
 */
package fifo_pkg;

    // Buffer geometry
    localparam int DATA_WIDTH  = 36;
    localparam int DEPTH       = 1024;
    localparam int ADDR_WIDTH  = 10;
    localparam int COUNT_WIDTH = 11;
    localparam int THR_WIDTH   = 12;

    // Word-count landmarks
    localparam logic [COUNT_WIDTH-1:0] DEPTH_COUNT = 11'h400;
    localparam logic [COUNT_WIDTH-1:0] HALF_COUNT  = 11'h200;
    localparam logic [COUNT_WIDTH-1:0] ZERO_COUNT  = 11'h000;

    // Register stages behind the flags
    localparam int EMPTY_FULL_STAGES = 2;
    localparam int READY_STAGES      = 3;

    // Register port
    localparam int REG_ADDR_WIDTH = 4;
    localparam int REG_DATA_WIDTH = 32;
    localparam logic [REG_ADDR_WIDTH-1:0] EMPTY_OFFSET_ADDR = 4'h0;
    localparam logic [REG_ADDR_WIDTH-1:0] FULL_OFFSET_ADDR  = 4'h4;
    localparam logic [REG_ADDR_WIDTH-1:0] STATUS_ADDR       = 4'h8;

    // Offset reset values
    localparam logic [ADDR_WIDTH-1:0] EMPTY_OFFSET_RESET = 10'h07F;
    localparam logic [ADDR_WIDTH-1:0] FULL_OFFSET_RESET  = 10'h07F;

    // Status register field positions
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_MODE_BIT  = 16;
    localparam int STATUS_FLAGS_LSB = 24;

    // Status flags as presented at the pins
    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic input_space_n;
        logic output_ready_n;
        logic almost_empty_n;
        logic almost_full_n;
        logic half_full_n;
    } flags_type;

    localparam flags_type FLAGS_RESET = 7'h2B;

    // Programmable offsets
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] empty_offset;
        logic [ADDR_WIDTH-1:0] full_offset;
    } offsets_type;

endpackage

//--- rtl/pin_sync.sv
/*
 * Three-stage synchroniser for a level arriving from a pin.
 * The output changes only once the second and third stages agree.
 * Not reset, so it keeps sampling while the block is held in reset.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    input  wire logic clk,
    input  wire logic din,
    output var  logic dout
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // Sampling chain; only the second stage reads the first
    always_ff @(posedge clk) begin
        s1_reg <= din;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // Accept a change once the two later stages agree
    always_ff @(posedge clk) begin
        if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    assign dout = level_reg;

endmodule

`default_nettype wire

//--- sim/fifo_user_model.sv
/*
 * Writer and reader logic facing the buffer's data ports.
 * Assumes it shares ref_clk with the buffer; the bench calls its tasks.
 */
`timescale 1ns/100ps
`default_nettype none

module fifo_user_model
    import fifo_pkg::*;
(
    input  wire logic                  ref_clk,
    output var  logic                  write_enable_n,
    output var  logic [DATA_WIDTH-1:0] data_in,
    output var  logic                  read_enable_n
);
    // Both ports idle from time zero
    initial begin
        write_enable_n = 1'b1;
        read_enable_n  = 1'b1;
        data_in        = '0;
    end

    // Word pattern: a marker nibble above the sequence number
    function automatic logic [DATA_WIDTH-1:0] word_of(input int k);
        return {4'hA, 32'(k)};
    endfunction

    // Writes n words on consecutive edges with enable held low
    task automatic write_words(input int base, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            write_enable_n <= 1'b0;
            data_in        <= word_of(base + i);
        end
        @(posedge ref_clk);
        write_enable_n <= 1'b1;
        data_in        <= ~data_in; // Released bus must not show a stale word
    endtask

    // Requests n words on consecutive edges, the first one included
    task automatic read_words(input int n);
        @(posedge ref_clk);
        read_enable_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        read_enable_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

//--- sim/tb_dual_clock_fifo_flag_modes.sv
/*
 * Self-checking bench: both timing modes, flag thresholds, register port.
 * Assumes the buffer and fifo_user_model share one 200 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_dual_clock_fifo_flag_modes
    import fifo_pkg::*;
;
    logic                      ref_clk;
    logic                      reset_n;
    logic                      mode_select_serial_in;
    logic                      write_enable_n;
    logic [DATA_WIDTH-1:0]     data_in;
    logic                      read_enable_n;
    logic [REG_ADDR_WIDTH-1:0] reg_addr;
    logic [REG_DATA_WIDTH-1:0] reg_wdata;
    logic                      reg_write;
    logic                      reg_read;
    logic [REG_DATA_WIDTH-1:0] reg_rdata;
    logic [DATA_WIDTH-1:0]     data_out;
    logic                      fall_through_mode;
    logic                      empty_flag_n;
    logic                      full_flag_n;
    logic                      input_space_n;
    logic                      output_ready_n;
    logic                      almost_empty_flag_n;
    logic                      almost_full_flag_n;
    logic                      half_full_flag_n;
    flags_type                 seen;
    logic                      ft_sel;
    int                        n_sel;
    int                        m_sel;
    int                        miscompares;
    int                        num_checks;

    // Flag pins gathered in package order
    assign seen = {empty_flag_n, full_flag_n, input_space_n, output_ready_n,
                   almost_empty_flag_n, almost_full_flag_n, half_full_flag_n};

    dual_clock_fifo_flag_modes dual_clock_fifo_flag_modes_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .mode_select_serial_in(mode_select_serial_in),
        .write_enable_n(write_enable_n), .data_in(data_in), .read_enable_n(read_enable_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .data_out(data_out),
        .fall_through_mode(fall_through_mode), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .input_space_n(input_space_n),
        .output_ready_n(output_ready_n), .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n));

    fifo_user_model fifo_user_model_i (
        .ref_clk(ref_clk), .write_enable_n(write_enable_n), .data_in(data_in),
        .read_enable_n(read_enable_n));

    // Clock generation
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Expected pins for c stored words; fall-through counts the output word too
    function automatic flags_type exp_flags(input int c, input logic ft, input int n,
                                            input int m);
        int        e;
        flags_type f;
        e = ft ? 1 : 0;
        f.empty_n        = ft | (c >= 1);
        f.full_n         = ft | (c < DEPTH);
        f.input_space_n  = ft & (c >= DEPTH + 1);
        f.output_ready_n = ~ft | (c < 1);
        f.almost_empty_n = c >= n + 1 + e;
        f.almost_full_n  = c < DEPTH + e - m;
        f.half_full_n    = c < DEPTH / 2 + 1 + e;
        return f;
    endfunction

    // Bounded wait for the flags to settle, then compare
    task automatic check_flags(input int c);
        flags_type f;
        int        t;
        f = exp_flags(c, ft_sel, n_sel, m_sel);
        #1;
        for (t = 0; t < 8 && seen !== f; t++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(seen, f)
    endtask

    // Register write, one strobe cycle
    task automatic reg_wr(input logic [REG_ADDR_WIDTH-1:0] a,
                          input logic [REG_DATA_WIDTH-1:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // Register read, data sampled in the cycle after the strobe
    task automatic reg_rd(input logic [REG_ADDR_WIDTH-1:0] a,
                          output logic [REG_DATA_WIDTH-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Reads c words singly, checking order and flags after each
    task automatic drain(input int base, input int c);
        for (int i = 0; i < c; i++) begin
            if (ft_sel) `CHK(data_out, fifo_user_model_i.word_of(base + i))
            fifo_user_model_i.read_words(1);
            #1;
            if (!ft_sel) `CHK(data_out, fifo_user_model_i.word_of(base + i))
            check_flags(c - 1 - i);
        end
        fifo_user_model_i.read_words(1);
        check_flags(0);
        if (!ft_sel) `CHK(data_out, fifo_user_model_i.word_of(base + c - 1))
    endtask

    // One full pass in one timing mode
    task automatic run_mode(input logic ft, input int n, input int m);
        logic [REG_DATA_WIDTH-1:0] d;
        int                        cap;
        ft_sel = ft;
        n_sel  = EMPTY_OFFSET_RESET;
        m_sel  = FULL_OFFSET_RESET;
        cap    = ft ? DEPTH + 1 : DEPTH;
        @(posedge ref_clk);
        mode_select_serial_in <= ft;
        reset_n               <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        check_flags(0);
        `CHK(fall_through_mode, ft)
        reg_rd(EMPTY_OFFSET_ADDR, d);
        `CHK(d[ADDR_WIDTH-1:0], EMPTY_OFFSET_RESET)
        reg_rd(FULL_OFFSET_ADDR, d);
        `CHK(d[ADDR_WIDTH-1:0], FULL_OFFSET_RESET)
        reg_rd(4'hC, d);
        `CHK(d, 32'h0000_0000)
        reg_rd(STATUS_ADDR, d);
        `CHK(d[STATUS_MODE_BIT], ft)
        reg_wr(EMPTY_OFFSET_ADDR, 32'(n));
        mode_select_serial_in <= ~ft;
        reg_wr(FULL_OFFSET_ADDR, 32'(m));
        n_sel = n;
        m_sel = m;
        reg_rd(EMPTY_OFFSET_ADDR, d);
        `CHK(d[ADDR_WIDTH-1:0], 10'(n))
        // First word: flag latency counted from the taking edge
        fifo_user_model_i.write_words(0, 1);
        repeat ((ft ? READY_STAGES : EMPTY_FULL_STAGES) - 2) @(posedge ref_clk);
        #1;
        `CHK(ft ? ~output_ready_n : empty_flag_n, 1'b0)
        @(posedge ref_clk);
        #1;
        `CHK(ft ? ~output_ready_n : empty_flag_n, 1'b1)
        if (ft) `CHK(data_out, fifo_user_model_i.word_of(0))
        drain(0, 1);
        // Back-to-back burst in both directions
        fifo_user_model_i.write_words(100, 4);
        check_flags(4);
        reg_rd(STATUS_ADDR, d);
        `CHK(d[STATUS_COUNT_LSB +: COUNT_WIDTH], 11'h004)
        `CHK(d[STATUS_FLAGS_LSB +: $bits(flags_type)], exp_flags(4, ft, n, m))
        fifo_user_model_i.read_words(4);
        #1;
        if (!ft) `CHK(data_out, fifo_user_model_i.word_of(103))
        check_flags(0);
        // Fill past capacity; the last write is refused
        for (int k = 0; k <= cap; k++) begin
            fifo_user_model_i.write_words(200 + k, 1);
            check_flags(k < cap ? k + 1 : cap);
        end
        drain(200, cap);
        `CHK(fall_through_mode, ft)
    endtask

    // Prints counts and verdict, then stops
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_n               = 1'b0;
        mode_select_serial_in = 1'b0;
        reg_addr              = 4'h0;
        reg_wdata             = 32'h0000_0000;
        reg_write             = 1'b0;
        reg_read              = 1'b0;
        miscompares           = 0;
        num_checks            = 0;
        run_mode(1'b0, 1023, 0);
        run_mode(1'b1, 0, 1023);
        give_verdict();
    end
endmodule

`default_nettype wire
